// File: src/fptr_regs.svh
// Constants for the front panel trigger router
`ifndef FPTR_REGS_SVH
`define FPTR_REGS_SVH
`define FPTR_LINES       8
`define FPTR_SEGS        3
`define FPTR_PORTS       2
`define FPTR_VAR_10SLOT  1'h0
`define FPTR_VAR_18SLOT  1'h1
`endif

// File: src/fptr_pkg.sv
// Types for the front panel trigger router
`include "fptr_regs.svh"
package fptr_pkg;
  typedef logic [`FPTR_LINES-1:0] fptr_lines_t;
  // All three segment banks of trigger lines, index 0 is segment one
  typedef struct packed {
    fptr_lines_t [`FPTR_SEGS-1:0] seg;
  } fptr_bus_t;
  // Per-port route configuration
  typedef struct packed {
    logic                         dir_out;
    fptr_lines_t [`FPTR_SEGS-1:0] in_mask;
    logic [1:0]                   out_seg;
    logic [2:0]                   out_line;
  } fptr_cfg_t;
endpackage

// File: src/fptr_router.sv
// Front panel trigger port to backplane trigger line crossbar
`timescale 1ns/1ps
`default_nettype none
`include "fptr_regs.svh"
module fptr_router #(
  parameter int NPORT = `FPTR_PORTS
) (
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic                          variant,
  input  wire fptr_pkg::fptr_cfg_t [NPORT-1:0] cfg,
  input  wire logic [NPORT-1:0]              pin_i,
  output logic [NPORT-1:0]                   pin_o,
  output logic [NPORT-1:0]                   pin_oe,
  input  wire fptr_pkg::fptr_bus_t           trig_i,
  output fptr_pkg::fptr_bus_t                trig_o,
  output fptr_pkg::fptr_bus_t                trig_oe,
  output logic [NPORT-1:0]                   cfg_err
);
  import fptr_pkg::*;

  // Two-stage synchronisers; only the second stage is read
  logic [NPORT-1:0] pin_s1_r, pin_s2_r;
  fptr_bus_t        trg_s1_r, trg_s2_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      trg_s1_r <= '0;
      trg_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
      trg_s1_r <= trig_i;
      trg_s2_r <= trg_s1_r;
    end
  end

  // Segments the front panel may reach, by chassis variant
  fptr_lines_t [`FPTR_SEGS-1:0] seg_ok;
  always_comb begin
    if (variant == `FPTR_VAR_18SLOT) begin
      seg_ok = {{`FPTR_LINES{1'b1}}, {`FPTR_LINES{1'b1}}, {`FPTR_LINES{1'b0}}};
    end else begin
      seg_ok = {{`FPTR_LINES{1'b0}}, {`FPTR_LINES{1'b1}}, {`FPTR_LINES{1'b1}}};
    end
  end

  // Output-source segment legal only if inside the permitted set.
  // Code 3 names no segment at all and is refused on both chassis,
  // so the crossbar never indexes past the last segment bank.
  function automatic logic seg_legal(input logic [1:0] s, input logic v);
    seg_legal = v ? (s == 2'h1 || s == 2'h2) : (s == 2'h0 || s == 2'h1);
  endfunction

  fptr_bus_t        trig_o_nxt, trig_oe_nxt, trig_o_r, trig_oe_r;
  logic [NPORT-1:0] pin_o_nxt, pin_oe_nxt, err_nxt;
  logic [NPORT-1:0] pin_o_r, pin_oe_r, err_r;

  // Latency seen from outside:
  //   cfg or variant change  -> outputs one edge later
  //   pin level change       -> backplane line three edges later
  //   backplane line change  -> front-panel pin three edges later
  // Two synchroniser stages plus the output register cost the three
  // edges; that was traded for clean, glitch-free pins on both sides.
  // Several input ports that share a line are ORed, so any one of them
  // raising its pin raises the line.
  // Crossbar: inputs OR onto chosen lines, outputs pick one line
  always_comb begin
    trig_o_nxt  = '0;
    trig_oe_nxt = '0;
    pin_o_nxt   = '0;
    pin_oe_nxt  = '0;
    err_nxt     = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (!cfg[p].dir_out) begin
        for (int s = 0; s < `FPTR_SEGS; s++) begin
          // Fan out only to permitted lines; pin never driven
          trig_oe_nxt.seg[s] = trig_oe_nxt.seg[s] | (cfg[p].in_mask[s] & seg_ok[s]);
          trig_o_nxt.seg[s]  = trig_o_nxt.seg[s]
                             | (cfg[p].in_mask[s] & seg_ok[s] & {`FPTR_LINES{pin_s2_r[p]}});
        end
      end else if (seg_legal(cfg[p].out_seg, variant)) begin
        // One line of one segment; encoding makes several impossible
        pin_oe_nxt[p] = 1'b1;
        pin_o_nxt[p]  = trg_s2_r.seg[cfg[p].out_seg][cfg[p].out_line];
      end else begin
        err_nxt[p] = 1'b1; // Illegal segment: leave pin undriven
      end
    end
  end

  // Register all outputs so pins are glitch free
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_o_r  <= '0;
      trig_oe_r <= '0;
      pin_o_r   <= '0;
      pin_oe_r  <= '0;
      err_r     <= '0;
    end else begin
      trig_o_r  <= trig_o_nxt;
      trig_oe_r <= trig_oe_nxt;
      pin_o_r   <= pin_o_nxt;
      pin_oe_r  <= pin_oe_nxt;
      err_r     <= err_nxt;
    end
  end

  assign trig_o  = trig_o_r;
  assign trig_oe = trig_oe_r;
  assign pin_o   = pin_o_r;
  assign pin_oe  = pin_oe_r;
  assign cfg_err = err_r;

  // Segment one is never driven on the large chassis
  chk_seg1_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    $stable(variant) && variant ##1 variant |-> trig_oe.seg[0] == '0)
    else $error("segment one driven on eighteen-slot chassis");
  // Segment three is never driven on the small chassis
  chk_seg3_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    !variant ##1 !variant |-> trig_oe.seg[2] == '0)
    else $error("segment three driven on ten-slot chassis");
  // Output port with legal route drives its pin next cycle
  chk_out_drives: assert property (@(posedge mclk) disable iff (sys_rst)
    cfg[0].dir_out && seg_legal(cfg[0].out_seg, variant) |=> pin_oe[0])
    else $error("output port not driven");
  // Input port never drives the pin
  chk_in_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    !cfg[0].dir_out |=> !pin_oe[0])
    else $error("input port drives its pin");
  // Input fan-out covers every masked line of segment two, legal on both chassis
  chk_in_fanout: assert property (@(posedge mclk) disable iff (sys_rst)
    !cfg[0].dir_out |=>
      (trig_oe.seg[1] & $past(cfg[0].in_mask[1])) == $past(cfg[0].in_mask[1]))
    else $error("fan-out mismatch");
  // Output pin follows chosen line two cycles after sampling
  chk_out_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    cfg[0].dir_out && $stable(cfg[0]) |=> !pin_oe[0] || pin_o[0] ==
      $past(trg_s2_r.seg[cfg[0].out_seg][cfg[0].out_line]))
    else $error("output pin wrong source");
  // Direction switch takes effect in one cycle
  chk_dir_switch: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(cfg[0].dir_out) |=>
      pin_oe[0] == $past(cfg[0].dir_out && seg_legal(cfg[0].out_seg, variant)))
    else $error("direction change mishandled");

  // Direction of every port gathered for the all-outputs guard
  logic [NPORT-1:0] dir_vec;
  always_comb begin
    dir_vec = '0;
    for (int p = 0; p < NPORT; p++) begin
      dir_vec[p] = cfg[p].dir_out;
    end
  end

  // With every port an output nothing may reach the backplane
  chk_out_no_line: assert property (@(posedge mclk) disable iff (sys_rst)
    &dir_vec |=> trig_oe == '0)
    else $error("output ports drive the backplane");

  // Per-port guards, repeated so that every port is watched, not only the first
  for (genvar gp = 0; gp < NPORT; gp++) begin : gen_port_chk
    // Legal output route: pin driven and no error flagged
    chk_port_route: assert property (@(posedge mclk) disable iff (sys_rst)
      cfg[gp].dir_out && seg_legal(cfg[gp].out_seg, variant)
      |=> pin_oe[gp] && !cfg_err[gp])
      else $error("legal output route not driven");
    // Unreachable segment: error raised, pin left alone
    chk_port_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
      cfg[gp].dir_out && !seg_legal(cfg[gp].out_seg, variant)
      |=> cfg_err[gp] && !pin_oe[gp])
      else $error("unreachable segment not refused");
    // Input port: pin quiet and no error
    chk_port_input: assert property (@(posedge mclk) disable iff (sys_rst)
      !cfg[gp].dir_out |=> !pin_oe[gp] && !cfg_err[gp])
      else $error("input port drives its pin");
    // High pin on an input reaches a masked line of segment two
    chk_port_data: assert property (@(posedge mclk) disable iff (sys_rst)
      !cfg[gp].dir_out && cfg[gp].in_mask[1][0] && pin_s2_r[gp] |=> trig_o.seg[1][0])
      else $error("input level not copied to line");
    // Steady output route copies the synchronised line
    chk_port_src: assert property (@(posedge mclk) disable iff (sys_rst)
      cfg[gp].dir_out && $stable(cfg[gp]) && $stable(variant)
      && seg_legal(cfg[gp].out_seg, variant)
      |=> pin_o[gp] == $past(trg_s2_r.seg[cfg[gp].out_seg][cfg[gp].out_line]))
      else $error("output pin wrong source");
  end
endmodule
`default_nettype wire

// File: tb/fptr_backplane.sv
// Backplane trigger lines with pull-ups and other modules' drivers
`timescale 1ns/1ps
`default_nettype none
module fptr_backplane (
  input  wire fptr_pkg::fptr_bus_t trig_o,
  input  wire fptr_pkg::fptr_bus_t trig_oe,
  input  wire fptr_pkg::fptr_bus_t drv_val,
  input  wire fptr_pkg::fptr_bus_t drv_en,
  output fptr_pkg::fptr_bus_t      trig_i
);
  // Router wins where it drives, then other modules; a released line floats high
  assign trig_i = (trig_oe & trig_o) | (~trig_oe & drv_en & drv_val) | (~trig_oe & ~drv_en);
endmodule
`default_nettype wire

// File: tb/fptr_router_tb.sv
// Self-checking bench for the front panel trigger router
`timescale 1ns/1ps
`default_nettype none
module fptr_router_tb;
  import fptr_pkg::*;
  logic            mclk;
  logic            sys_rst;
  logic            variant;
  fptr_cfg_t [1:0] cfg;
  logic [1:0]      ext_pin;
  logic [1:0]      pin_o;
  logic [1:0]      pin_oe;
  logic [1:0]      cfg_err;
  fptr_bus_t       trig_i;
  fptr_bus_t       trig_o;
  fptr_bus_t       trig_oe;
  fptr_bus_t       drv_val;
  fptr_bus_t       drv_en;
  int              failures;
  int              check_count;
  // Pin level: router drives when enabled, else the external equipment
  wire logic [1:0] pin_w = (pin_oe & pin_o) | (~pin_oe & ext_pin);
  fptr_router #(.NPORT(2)) fptr_router_inst (.mclk(mclk), .sys_rst(sys_rst), .variant(variant),
    .cfg(cfg), .pin_i(pin_w), .pin_o(pin_o), .pin_oe(pin_oe), .trig_i(trig_i),
    .trig_o(trig_o), .trig_oe(trig_oe), .cfg_err(cfg_err));
  fptr_backplane fptr_backplane_inst (.trig_o(trig_o), .trig_oe(trig_oe), .drv_val(drv_val),
    .drv_en(drv_en), .trig_i(trig_i));
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // Sync plus register path is three edges; sample after the fourth settles
  task automatic settle;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic fan_in(logic v, logic [7:0] e0, logic [7:0] e2);
    @(posedge mclk);
    variant <= v;
    cfg[0] <= '{1'b0, {8'h0F, 8'h21, 8'h80}, 2'h0, 3'h0};
    ext_pin[0] <= 1'b1;
    settle;
    chk("oe seg0", e0, trig_oe.seg[0]);
    chk("oe seg1", 8'h21, trig_oe.seg[1]);
    chk("oe seg2", e2, trig_oe.seg[2]);
    chk("data seg1", 8'h21, trig_o.seg[1] & 8'h21);
    chk("pin oe", 8'h00, pin_oe[0]);
    ext_pin[0] <= 1'b0;
    settle;
    chk("data low", 8'h00, trig_o.seg[1] & 8'h21);
  endtask
  task automatic out_route;
    @(posedge mclk);
    cfg[0] <= '0;
    cfg[1] <= '{1'b1, {8'hFF, 8'hFF, 8'hFF}, 2'h2, 3'h6};
    drv_en <= '1;
    drv_val <= {8'h40, 8'h00, 8'h00};
    settle;
    chk("pin oe", 8'h02, pin_oe);
    chk("pin val", 8'h01, pin_o[1]);
    chk("no line", 8'h00, |trig_oe);
    drv_val <= {8'hBF, 8'hFF, 8'hFF};
    settle;
    chk("one line", 8'h00, pin_o[1]);
    cfg[1].out_seg <= 2'h0;
    settle;
    chk("err 18", 8'h02, cfg_err);
    chk("oe 18", 8'h00, pin_oe);
    variant <= 1'b0;
    settle;
    chk("err 10", 8'h00, cfg_err);
    chk("oe 10", 8'h02, pin_oe);
    chk("pin 10", 8'h01, pin_o[1]);
    cfg[1].dir_out <= 1'b0;
    settle;
    chk("dir flip", 8'h00, pin_oe);
  endtask
  // Two inputs on one line are ORed; pin 1 high alone raises it
  task automatic fan_or;
    @(posedge mclk);
    cfg[0] <= '{1'b0, {8'h00, 8'h01, 8'h00}, 2'h0, 3'h0};
    cfg[1] <= '{1'b0, {8'h00, 8'h01, 8'h00}, 2'h0, 3'h0};
    ext_pin <= 2'b10;
    settle;
    chk("or oe", 8'h01, trig_oe.seg[1]);
    chk("or one", 8'h01, trig_o.seg[1]);
    ext_pin <= 2'b00;
    settle;
    chk("or none", 8'h00, trig_o.seg[1]);
  endtask
  // Reset in mid-run clears every output, then the routes return
  task automatic mid_reset;
    @(posedge mclk);
    variant <= 1'b1;
    cfg[0] <= '{1'b0, {8'h00, 8'h02, 8'h00}, 2'h0, 3'h0};
    cfg[1] <= '{1'b1, {8'h00, 8'h00, 8'h00}, 2'h1, 3'h2};
    drv_en <= '0;
    settle;
    chk("pre oe", 8'h02, pin_oe);
    chk("pre pin", 8'h01, pin_o[1]);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("rst oe", 8'h00, pin_oe);
    chk("rst line", 8'h00, |trig_oe);
    @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk("rel oe", 8'h00, pin_oe);
    settle;
    chk("post oe", 8'h02, pin_oe);
    chk("post pin", 8'h01, pin_o[1]);
    chk("post line", 8'h02, trig_oe.seg[1]);
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {sys_rst, variant, cfg, ext_pin, drv_val, drv_en} = '0;
    sys_rst = 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    fan_in(1'b0, 8'h80, 8'h00);
    fan_in(1'b1, 8'h00, 8'h0F);
    out_route();
    fan_or();
    mid_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
